/* pkg/panel_pkg.sv */
// Shared constants, types and register map of the panel control block
package panel_pkg;
    localparam int unsigned CLK_HZ = 250000000;
    localparam int unsigned TICK_HZ = 1000;
    localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned SHOW_MS = 1000;
    localparam int unsigned DISPLAY_MS = 2000;
    localparam int unsigned APPLY_MS = 2000;
    localparam int unsigned FACTORY_MS = 3000;
    localparam int unsigned GND_QUAL_MS = 5000;
    localparam logic [7:0] ADDR_MAX = 8'hFA;
    localparam logic [7:0] ADDR_ALONE = 8'h00;
    localparam int unsigned NUM_FAULTS = 10;
    localparam int unsigned FAULT_GND = 6;

    typedef enum logic [2:0] {
        RATE_10 = 3'b001,
        RATE_20 = 3'b010,
        RATE_62K5 = 3'b011,
        RATE_125 = 3'b100,
        RATE_250 = 3'b101,
        RATE_500 = 3'b110
    } rate_t;
    localparam rate_t RATE_DEFAULT = RATE_10;

    typedef enum logic [1:0] {
        BTN_IDLE = 2'b00,
        BTN_HELD = 2'b01,
        BTN_SHOW = 2'b10,
        BTN_EDIT = 2'b11
    } btn_state_t;

    typedef struct packed {
        logic [2:0] lights;
        logic fault_led;
        logic gnd_led;
    } panel_leds_t;

    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_MASK = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam logic [3:0] OFF_FAULTS = 4'hC;
    localparam logic [9:0] MASK_RESET = 10'h3FF;
endpackage

/* src/ms_timer.sv */
// Millisecond counter with clear, saturating at its top
`timescale 1ns/10ps
`default_nettype none
module ms_timer #(
    parameter int unsigned WIDTH = 13
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic tick_i,
    input wire logic clear_i,
    output logic [WIDTH-1:0] count_o
);
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_o <= '0;
        end else if (clear_i) begin
            count_o <= '0;
        end else if (tick_i && (count_o != {WIDTH{1'b1}})) begin
            count_o <= count_o + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* src/panel_ctrl.sv */
// Front panel: address decode, bit-rate display and step, faults, standby, AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
module panel_ctrl #(
    parameter int unsigned TICK_DIV = panel_pkg::TICK_DIV,
    parameter int unsigned DEBOUNCE_MS = panel_pkg::DEBOUNCE_MS,
    parameter int unsigned GND_QUAL_MS = panel_pkg::GND_QUAL_MS
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [3:0] addr_high_i,
    input wire logic [3:0] addr_low_i,
    input wire logic button_i,
    input wire logic [panel_pkg::NUM_FAULTS-1:0] faults_i,
    input wire logic bus_connected_i,
    input wire logic standby_cmd_on_i,
    input wire logic standby_cmd_off_i,
    input wire logic stage_supply_i,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output panel_pkg::panel_leds_t leds_o,
    output logic [7:0] node_addr_o,
    output logic addr_valid_o,
    output logic stand_alone_o,
    output logic bus_enable_o,
    output panel_pkg::rate_t rate_o,
    output logic standby_o,
    output logic standalone_mix_o,
    output logic factory_reset_o
);
    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick
    localparam int unsigned DIV_W = $clog2(TICK_DIV);
    logic [DIV_W-1:0] div_q;
    logic tick;
    assign tick = (div_q == DIV_W'(TICK_DIV - 1));
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            div_q <= '0;
        end else if (tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode and modes
    logic [7:0] addr;
    logic alone;
    assign addr = {addr_high_i, addr_low_i};
    assign alone = (addr == panel_pkg::ADDR_ALONE);
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            node_addr_o <= 8'h00;
            addr_valid_o <= 1'b0;
            stand_alone_o <= 1'b1;
            bus_enable_o <= 1'b0;
            standalone_mix_o <= 1'b1;
        end else begin
            node_addr_o <= addr;
            addr_valid_o <= !alone && (addr <= panel_pkg::ADDR_MAX);
            stand_alone_o <= alone;
            bus_enable_o <= !alone && (addr <= panel_pkg::ADDR_MAX);
            standalone_mix_o <= alone;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            standby_o <= 1'b0;
        end else if (!bus_connected_i || alone) begin
            standby_o <= 1'b0;
        end else if (standby_cmd_on_i) begin
            standby_o <= 1'b1;
        end else if (standby_cmd_off_i) begin
            standby_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Button debounce
    logic btn_q;
    logic [7:0] deb_cnt_q;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            btn_q <= 1'b0;
            deb_cnt_q <= 8'h00;
        end else if (button_i == btn_q) begin
            deb_cnt_q <= 8'h00;
        end else if (tick) begin
            if (deb_cnt_q >= 8'(DEBOUNCE_MS - 1)) begin
                btn_q <= button_i;
                deb_cnt_q <= 8'h00;
            end else begin
                deb_cnt_q <= deb_cnt_q + 8'h01;
            end
        end
    end
    logic btn_prev_q;
    logic press;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            btn_prev_q <= 1'b0;
        end else begin
            btn_prev_q <= btn_q;
        end
    end
    assign press = btn_q && !btn_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Rate display and stepping
    panel_pkg::btn_state_t state_q;
    panel_pkg::rate_t pending_q;
    logic [12:0] ms;
    logic tmr_clear;
    assign tmr_clear = (btn_q != btn_prev_q);
    ms_timer #(.WIDTH(13)) u_timer (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .tick_i(tick),
        .clear_i(tmr_clear),
        .count_o(ms)
    );

    function automatic panel_pkg::rate_t next_rate(input panel_pkg::rate_t r);
        next_rate = (r == panel_pkg::RATE_500) ? panel_pkg::RATE_10
                  : panel_pkg::rate_t'(r + 3'd1);
    endfunction

    logic factory;
    assign factory = (state_q == panel_pkg::BTN_HELD) && btn_q
                   && (ms >= 13'(panel_pkg::FACTORY_MS));
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= panel_pkg::BTN_IDLE;
            pending_q <= panel_pkg::RATE_DEFAULT;
        end else begin
            case (state_q)
                panel_pkg::BTN_IDLE: begin
                    if (press) begin
                        state_q <= panel_pkg::BTN_HELD;
                    end
                end
                panel_pkg::BTN_HELD: begin
                    if (factory) begin
                        state_q <= panel_pkg::BTN_IDLE;
                    end else if (!btn_q) begin
                        if (ms >= 13'(panel_pkg::SHOW_MS)) begin
                            state_q <= alone ? panel_pkg::BTN_EDIT
                                             : panel_pkg::BTN_IDLE;
                        end else begin
                            state_q <= panel_pkg::BTN_IDLE;
                        end
                    end
                end
                panel_pkg::BTN_SHOW: begin
                    state_q <= panel_pkg::BTN_IDLE;
                end
                panel_pkg::BTN_EDIT: begin
                    if (!alone) begin
                        state_q <= panel_pkg::BTN_IDLE;
                    end else if (press) begin
                        pending_q <= next_rate(pending_q);
                    end else if (!btn_q && ms >= 13'(panel_pkg::APPLY_MS)) begin
                        state_q <= panel_pkg::BTN_IDLE;
                    end
                end
                default: begin
                    state_q <= panel_pkg::BTN_IDLE;
                end
            endcase
            if (state_q == panel_pkg::BTN_IDLE) begin
                pending_q <= rate_o;
            end
        end
    end

    // Rate shown for two seconds from the one-second mark
    logic [11:0] disp_cnt_q;
    logic disp_on;
    assign disp_on = (disp_cnt_q != 12'h000) || (state_q == panel_pkg::BTN_EDIT);
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            disp_cnt_q <= 12'h000;
        end else if (state_q == panel_pkg::BTN_HELD && btn_q
                     && ms == 13'(panel_pkg::SHOW_MS)) begin
            disp_cnt_q <= 12'(panel_pkg::DISPLAY_MS);
        end else if (factory) begin
            disp_cnt_q <= 12'h000;
        end else if (tick && disp_cnt_q != 12'h000) begin
            disp_cnt_q <= disp_cnt_q - 12'h001;
        end
    end

    logic wr_rate;
    logic [2:0] wr_rate_val;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rate_o <= panel_pkg::RATE_DEFAULT;
            factory_reset_o <= 1'b0;
        end else begin
            factory_reset_o <= 1'b0;
            if (factory && alone && !bus_connected_i) begin
                rate_o <= panel_pkg::RATE_DEFAULT;
                factory_reset_o <= 1'b1;
            end else if (state_q == panel_pkg::BTN_EDIT && alone && !btn_q
                         && ms >= 13'(panel_pkg::APPLY_MS)) begin
                rate_o <= pending_q;
            end else if (wr_rate && wr_rate_val >= 3'd1 && wr_rate_val <= 3'd6) begin
                rate_o <= panel_pkg::rate_t'(wr_rate_val);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Faults and ground-fault latch
    logic [panel_pkg::NUM_FAULTS-1:0] mask_q;
    logic [panel_pkg::NUM_FAULTS-1:0] live;
    logic gnd_q;
    logic [12:0] gnd_ms;
    logic gnd_seen;
    assign gnd_seen = faults_i[panel_pkg::FAULT_GND] && alone;
    ms_timer #(.WIDTH(13)) u_gnd_timer (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .tick_i(tick),
        .clear_i(!gnd_seen),
        .count_o(gnd_ms)
    );
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gnd_q <= 1'b0;
        end else if (gnd_seen && gnd_ms >= 13'(GND_QUAL_MS)) begin
            gnd_q <= 1'b1;
        end else if (!stage_supply_i || press) begin
            gnd_q <= 1'b0;
        end
    end
    generate
        for (genvar i = 0; i < panel_pkg::NUM_FAULTS; i++) begin : g_fault
            if (i == panel_pkg::FAULT_GND) begin : g_gnd
                assign live[i] = gnd_q && mask_q[i];
            end else begin : g_other
                assign live[i] = faults_i[i] && mask_q[i];
            end
        end
    endgenerate

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            leds_o <= '0;
        end else begin
            leds_o.lights <= disp_on ? pending_q : 3'b000;
            leds_o.fault_led <= |live;
            leds_o.gnd_led <= gnd_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic aw_q;
    logic w_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_wr;
    assign do_wr = aw_q && w_q && !s_axi_bvalid;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= !aw_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == panel_pkg::OFF_CTRL
                             || awaddr_q == panel_pkg::OFF_MASK) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign wr_rate = do_wr && awaddr_q == panel_pkg::OFF_CTRL && wstrb_q[0] && alone;
    assign wr_rate_val = wdata_q[2:0];
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mask_q <= panel_pkg::MASK_RESET;
        end else if (do_wr && awaddr_q == panel_pkg::OFF_MASK) begin
            if (wstrb_q[0]) begin
                mask_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
                mask_q[9:8] <= wdata_q[9:8];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                if (s_axi_araddr == panel_pkg::OFF_CTRL) begin
                    s_axi_rdata <= {29'h0, rate_o};
                end else if (s_axi_araddr == panel_pkg::OFF_MASK) begin
                    s_axi_rdata <= {22'h0, mask_q};
                end else if (s_axi_araddr == panel_pkg::OFF_STATUS) begin
                    s_axi_rdata <= {16'h0, node_addr_o, 2'b00, gnd_q, standby_o,
                                    stand_alone_o, addr_valid_o, state_q};
                end else if (s_axi_araddr == panel_pkg::OFF_FAULTS) begin
                    s_axi_rdata <= {22'h0, live};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/panel_ctrl_props.sv */
// Port-level assertions for the panel control block
`timescale 1ns/10ps
`default_nettype none
module panel_ctrl_props #(
    parameter int unsigned TICK_DIV = 10,
    parameter int unsigned GND_QUAL_MS = 20
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [3:0] addr_high_i,
    input wire logic [3:0] addr_low_i,
    input wire logic [panel_pkg::NUM_FAULTS-1:0] faults_i,
    input wire logic bus_connected_i,
    input wire logic standby_cmd_on_i,
    input wire panel_pkg::panel_leds_t leds_o,
    input wire logic [7:0] node_addr_o,
    input wire logic addr_valid_o,
    input wire logic stand_alone_o,
    input wire logic bus_enable_o,
    input wire panel_pkg::rate_t rate_o,
    input wire logic standby_o,
    input wire logic factory_reset_o
);
    logic [1:0] up_q;
    int unsigned gnd_run_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////////////
    // Past values are trusted only two edges after reset, else reset values leak in
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gnd_run_q <= 0;
        end else if (faults_i[panel_pkg::FAULT_GND] && stand_alone_o) begin
            gnd_run_q <= gnd_run_q + 1;
        end else begin
            gnd_run_q <= 0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    AST_ADDR: assert property (up_q[1] |-> node_addr_o == $past({addr_high_i, addr_low_i}))
        else $error("node address does not follow the switches");
    AST_VALID: assert property (up_q[1] |->
        addr_valid_o == ($past({addr_high_i, addr_low_i}) inside {[8'h01:8'hFA]}))
        else $error("address valid flag wrong");
    AST_ALONE: assert property (up_q[1] |->
        stand_alone_o == ($past({addr_high_i, addr_low_i}) == 8'h00) && !(stand_alone_o && bus_enable_o))
        else $error("stand-alone or bus enable wrong");
    AST_RATE_CODE: assert property (rate_o >= 3'h1 && rate_o <= 3'h6)
        else $error("rate code outside the six codes");
    AST_RATE_LOCK: assert property ($changed(rate_o) |-> stand_alone_o || $past(stand_alone_o))
        else $error("rate changed with a non-zero address");
    AST_FACTORY: assert property (factory_reset_o |->
        stand_alone_o && !bus_connected_i ##1 rate_o == panel_pkg::RATE_10)
        else $error("factory reset without its conditions or result");
    AST_GND_QUAL: assert property ($rose(leds_o.gnd_led) |->
        gnd_run_q >= (GND_QUAL_MS - 1) * TICK_DIV)
        else $error("ground light before the qualification time");
    AST_STBY_ON: assert property ($rose(standby_o) |-> $past(standby_cmd_on_i))
        else $error("standby entered without a command");
    AST_STBY_DROP: assert property ((!bus_connected_i || stand_alone_o) [*2] |-> !standby_o)
        else $error("standby kept without bus or at address zero");
    cover property ($rose(leds_o.gnd_led));
    cover property (factory_reset_o);
    cover property ($rose(standby_o));
    cover property ($changed(rate_o));
endmodule
`default_nettype wire

/* verif/panel_front.sv */
// Model of the rotary address switches and the recessed push button
`timescale 1ns/10ps
`default_nettype none
module panel_front (
    input wire logic clock_i,
    output logic [3:0] addr_high_o,
    output logic [3:0] addr_low_o,
    output logic button_o
);
    initial begin
        addr_high_o = 4'h0;
        addr_low_o = 4'h0;
        button_o = 1'b0;
    end
    task automatic set_addr(input logic [7:0] a);
        @(posedge clock_i);
        addr_high_o <= a[7:4];
        addr_low_o <= a[3:0];
    endtask
    // Contacts chatter on every change, shorter than the debounce window
    task automatic set_button(input logic v);
        repeat (3) begin
            @(posedge clock_i);
            button_o <= v;
            @(posedge clock_i);
            button_o <= !v;
        end
        @(posedge clock_i);
        button_o <= v;
    endtask
endmodule
`default_nettype wire

/* verif/can_address_baud_panel_ctrl_tb.sv */
// Self-checking bench for the panel control block
`timescale 1ns/10ps
`default_nettype none
module can_address_baud_panel_ctrl_tb;
    localparam int MS = 10;
    logic clock_i, rstn_i, button_i, bus_connected_i, standby_cmd_on_i, standby_cmd_off_i;
    logic stage_supply_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] addr_high_i, addr_low_i, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [9:0] faults_i;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    panel_pkg::panel_leds_t leds_o;
    panel_pkg::rate_t rate_o;
    logic [7:0] node_addr_o;
    logic addr_valid_o, stand_alone_o, bus_enable_o, standby_o, standalone_mix_o;
    logic factory_reset_o, seen;
    int n_fail = 0, compares = 0, n;
    logic [7:0] addrs [6] = '{8'h00, 8'h01, 8'h7F, 8'hFA, 8'hFB, 8'hFF};
    logic [2:0] steps [3] = '{3'b001, 3'b010, 3'b011};
    panel_ctrl #(.TICK_DIV(10), .DEBOUNCE_MS(1), .GND_QUAL_MS(20)) dut (.clock_i, .rstn_i,
        .addr_high_i, .addr_low_i, .button_i, .faults_i, .bus_connected_i, .standby_cmd_on_i,
        .standby_cmd_off_i, .stage_supply_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .leds_o, .node_addr_o, .addr_valid_o, .stand_alone_o,
        .bus_enable_o, .rate_o, .standby_o, .standalone_mix_o, .factory_reset_o);
    panel_front front (.clock_i, .addr_high_o(addr_high_i), .addr_low_o(addr_low_i),
        .button_o(button_i));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = !clock_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
        compares++;
        if (seen_v !== exp) begin
            n_fail++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen_v);
        end
    endtask
    task automatic wait_ms(input int k);
        repeat (k * MS) @(posedge clock_i);
    endtask
    // Response code xx means the code is not judged
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic b_d = 1'b0;
        @(posedge clock_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 50 && !b_d; k++) begin
            @(posedge clock_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                b_d = 1'b1;
                s_axi_bready <= 1'b0;
                if (er !== 2'bxx) check("bresp", s_axi_bresp, er);
            end
        end
        if (!b_d) begin
            n_fail++;
            end_of_test();
        end
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic r_d = 1'b0;
        @(posedge clock_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int k = 0; k < 50 && !r_d; k++) begin
            @(posedge clock_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                r_d = 1'b1;
                s_axi_rready <= 1'b0;
                check("rdata", s_axi_rdata, exp);
                check("rresp", s_axi_rresp, er);
            end
        end
        if (!r_d) begin
            n_fail++;
            end_of_test();
        end
    endtask
    task automatic stby_cmd(input logic on);
        @(posedge clock_i);
        standby_cmd_on_i <= on;
        standby_cmd_off_i <= !on;
        @(posedge clock_i);
        standby_cmd_on_i <= 1'b0;
        standby_cmd_off_i <= 1'b0;
        repeat (2) @(posedge clock_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn_i, bus_connected_i, standby_cmd_on_i, standby_cmd_off_i} = 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, faults_i} = 50'h0;
        s_axi_wstrb = 4'hF;
        stage_supply_i = 1'b1;
        repeat (3) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        check("rate", rate_o, panel_pkg::RATE_10);
        axi_rd(4'h4, 32'h0000_03FF, 2'b00);
        axi_rd(4'h2, 32'h0, 2'b10);
        foreach (addrs[i]) begin
            front.set_addr(addrs[i]);
            repeat (3) @(posedge clock_i);
            check("node", node_addr_o, addrs[i]);
            check("valid", addr_valid_o, addrs[i] inside {[8'h01:8'hFA]});
            check("alone", stand_alone_o, addrs[i] == 8'h00);
            check("mix", standalone_mix_o, addrs[i] == 8'h00);
        end
        front.set_addr(8'h12);
        axi_wr(4'h0, 32'h5, 2'bxx);
        axi_rd(4'h0, 32'h1, 2'b00);
        bus_connected_i <= 1'b1;
        stby_cmd(1'b1);
        check("stby_on", standby_o, 1'b1);
        stby_cmd(1'b0);
        check("stby_off", standby_o, 1'b0);
        stby_cmd(1'b1);
        bus_connected_i <= 1'b0;
        wait_ms(1);
        check("stby_bus", standby_o, 1'b0);
        bus_connected_i <= 1'b1;
        stby_cmd(1'b1);
        front.set_addr(8'h00);
        wait_ms(1);
        check("stby_addr", standby_o, 1'b0);
        $display("test address and standby done");
        for (int i = 0; i < 10; i++) begin
            if (i != panel_pkg::FAULT_GND) begin
                faults_i <= 10'h1 << i;
                repeat (3) @(posedge clock_i);
                check("fault", leds_o.fault_led, 1'b1);
                axi_rd(4'hC, 32'h1 << i, 2'b00);
            end
        end
        faults_i <= 10'h004;
        axi_wr(4'h4, 32'h3FB, 2'b00);
        repeat (3) @(posedge clock_i);
        check("masked", leds_o.fault_led, 1'b0);
        s_axi_wstrb <= 4'h1;
        axi_wr(4'h4, 32'h0FF, 2'b00);
        axi_rd(4'h4, 32'h3FF, 2'b00);
        faults_i <= 10'h040;
        wait_ms(15);
        faults_i <= 10'h000;
        wait_ms(2);
        check("gnd_short", leds_o.gnd_led, 1'b0);
        faults_i <= 10'h040;
        wait_ms(25);
        faults_i <= 10'h000;
        wait_ms(2);
        check("gnd_latch", leds_o.gnd_led, 1'b1);
        stage_supply_i <= 1'b0;
        wait_ms(1);
        check("gnd_supply", leds_o.gnd_led, 1'b0);
        stage_supply_i <= 1'b1;
        faults_i <= 10'h040;
        wait_ms(25);
        faults_i <= 10'h000;
        front.set_button(1'b1);
        wait_ms(3);
        front.set_button(1'b0);
        wait_ms(2);
        check("gnd_button", leds_o.gnd_led, 1'b0);
        front.set_addr(8'h12);
        faults_i <= 10'h040;
        wait_ms(25);
        check("gnd_net", leds_o.gnd_led, 1'b0);
        faults_i <= 10'h000;
        front.set_addr(8'h00);
        bus_connected_i <= 1'b0;
        $display("test faults done");
        for (int c = 1; c <= 6; c++) begin
            axi_wr(4'h0, c, 2'b00);
            axi_rd(4'h0, c, 2'b00);
            check("rate_code", rate_o, c);
        end
        front.set_button(1'b1);
        wait_ms(1050);
        check("show", leds_o.lights, panel_pkg::RATE_500);
        front.set_button(1'b0);
        wait_ms(5);
        foreach (steps[i]) begin
            front.set_button(1'b1);
            wait_ms(5);
            front.set_button(1'b0);
            wait_ms(5);
            check("step", leds_o.lights, steps[i]);
        end
        wait_ms(1900);
        check("pending", rate_o, panel_pkg::RATE_500);
        wait_ms(200);
        check("applied", rate_o, panel_pkg::RATE_62K5);
        $display("test rate step done");
        axi_wr(4'h0, 32'h4, 2'b00);
        seen = 1'b0;
        front.set_button(1'b1);
        for (n = 0; n < 3200 * MS && !seen; n++) begin
            @(posedge clock_i);
            seen = factory_reset_o;
        end
        check("factory", seen, 1'b1);
        check("hold_time", n >= 2990 * MS, 1'b1);
        front.set_button(1'b0);
        wait_ms(2200);
        check("factory_rate", rate_o, panel_pkg::RATE_10);
        $display("test factory done");
        end_of_test();
    end
endmodule
bind panel_ctrl panel_ctrl_props #(.TICK_DIV(TICK_DIV), .GND_QUAL_MS(GND_QUAL_MS)) props (
    .clock_i, .rstn_i, .addr_high_i, .addr_low_i, .faults_i, .bus_connected_i,
    .standby_cmd_on_i, .leds_o, .node_addr_o, .addr_valid_o, .stand_alone_o, .bus_enable_o,
    .rate_o, .standby_o, .factory_reset_o);
`default_nettype wire
